/* rtl/fip_pkg.sv */
// shared constants, types and timing for the flash identification / protection host
package fip_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int NUM_SECT = 35;
   localparam int CLK_NS = 5;
   localparam int ACC_NS = 70;
   localparam int WE_NS = 35;
   localparam int HV_SETUP_NS = 4000;
   localparam int RST_PULSE_NS = 500;
   localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_CYC = (WE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HV_CYC = (HV_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 12;
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h0_0555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h0_02AA;
   localparam logic [ADDR_W-1:0] SEC_BASE = 20'hF_8000;
   localparam logic [6:0] ESN_LAST = 7'h07;
   localparam int SECT_LSB = 12;
   localparam int A6_POS = 6;
   localparam int IND_LOCK_BIT = 7;
   localparam int PROT_BIT = 0;
   localparam logic [7:0] IND_LOCKED = 8'h83;
   localparam logic [7:0] IND_OPEN = 8'h03;
   localparam logic [7:0] PROT_NO = 8'h00;
   localparam logic [7:0] PROT_YES = 8'h01;

   typedef enum logic [3:0] {
      OP_READ, OP_WRITE, OP_ID_HV, OP_ID_CMD, OP_SEC_ENTER, OP_SEC_EXIT,
      OP_SEC_READ, OP_PROT_WR, OP_UNPROT_WR, OP_HW_RESET
   } fip_op_e;

   // A6, A1, A0 pattern of each item
   typedef enum logic [2:0] {
      ID_MAKER = 3'b000, ID_DEVICE = 3'b001, ID_PROT = 3'b010, ID_SECIND = 3'b101
   } fip_item_e;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_SETUP = 3'b001, S_STROBE = 3'b011, S_HOLD = 3'b010,
      S_DONE = 3'b110, S_RSTP = 3'b111
   } fip_state_e;

   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic last;
   } fip_step_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_n;
      logic reset_hv;
      logic a9_hv;
   } fip_pins_s;
endpackage

/* rtl/fip_host.sv */
// host controller driving the flash identification, protection and secured region pins
//
// Notes on behaviour
// - elevated voltage on the address pin held through the whole high-voltage read.
// - A6, A1, A0 pick maker, device, protection state or secured-region indicator.
// - protection read puts sector on top bits; 00h unprotected, 01h protected.
// - before first unprotect write every sector must already be protected.
// - protect and unprotect use elevated reset pin and ordinary bus cycles.
`timescale 1ns/100ps
`default_nettype none
module fip_host
   import fip_pkg::*;
#(
   parameter logic [7:0] CMD_UNLK1 = 8'h11,
   parameter logic [7:0] CMD_UNLK2 = 8'h22,
   parameter logic [7:0] CMD_AUTOSEL = 8'h33,
   parameter logic [7:0] CMD_RESET = 8'h44,
   parameter logic [7:0] CMD_SEC_ENTER = 8'h55,
   parameter logic [7:0] CMD_SEC_EXIT = 8'h66,
   parameter logic [7:0] CMD_BYPASS = 8'h77,
   parameter logic ESN_ONLY = 1'b1
) (
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic REQ,
   output logic READY,
   input wire fip_pkg::fip_op_e OP,
   input wire fip_pkg::fip_item_e ITEM,
   input wire logic [fip_pkg::ADDR_W-1:0] ADDR,
   input wire logic [fip_pkg::DATA_W-1:0] WDATA,
   input wire logic [5:0] SECTOR,
   input wire logic BYTE_MODE,
   input wire logic ACC_REQ,
   input wire logic TEMP_UNPROT,
   output logic DONE,
   output logic ERR,
   output logic [fip_pkg::DATA_W-1:0] RDATA,
   output logic SECURED,
   output logic FACTORY_LOCKED,
   output logic [fip_pkg::NUM_SECT-1:0] PROT_MAP,
   output logic [fip_pkg::ADDR_W-1:0] F_ADDR,
   input wire logic [fip_pkg::DATA_W-1:0] F_DQ_I,
   output logic [fip_pkg::DATA_W-1:0] F_DQ_O,
   output logic F_DQ_OE,
   output logic F_CE_N,
   output logic F_OE_N,
   output logic F_WE_N,
   output logic F_RESET_N,
   output logic F_RESET_HV_EN,
   output logic F_A9_HV_EN,
   output logic F_BYTE_N,
   output logic F_ACC_EN
);
   import fip_pkg::*;
   typedef struct packed {
      fip_state_e st;
      fip_op_e op;
      fip_item_e item;
      logic [2:0] step;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [5:0] sector;
      logic [DATA_W-1:0] rdata;
      logic done;
      logic err;
      logic secured;
      logic locked;
      logic [NUM_SECT-1:0] prot;
      logic [DATA_W-1:0] s1, s2, s3;
      fip_pins_s pin;
   } fip_state_s;

   fip_state_s r, next_r;
   function automatic fip_step_s step_of(fip_op_e op, logic [2:0] i, logic [ADDR_W-1:0] a,
                                         logic [DATA_W-1:0] d, fip_item_e it);
      fip_step_s s;
      logic [ADDR_W-1:0] ida;
      s = '0;
      ida = '0;
      ida[ADDR_W-1:SECT_LSB] = a[ADDR_W-1:SECT_LSB];
      ida[A6_POS] = it[2];
      ida[1:0] = it[1:0];
      case (i)
         3'd0: s = '{1'b1, UNLOCK_A1, {8'h00, CMD_UNLK1}, 1'b0};
         3'd1: s = '{1'b1, UNLOCK_A2, {8'h00, CMD_UNLK2}, 1'b0};
         default: s = '{1'b1, '0, {8'h00, CMD_RESET}, 1'b1};
      endcase
      unique case (op)
         OP_READ: s = '{1'b0, a, '0, 1'b1};
         OP_SEC_READ: s = '{1'b0, SEC_BASE | {13'h0000, a[6:0]}, '0, 1'b1};
         OP_WRITE, OP_PROT_WR, OP_UNPROT_WR: s = '{1'b1, a, d, 1'b1};
         OP_ID_HV: s = '{1'b0, ida, '0, 1'b1};
         OP_ID_CMD: begin
            if (i == 3'd2) begin
               s = '{1'b1, UNLOCK_A1, {8'h00, CMD_AUTOSEL}, 1'b0};
            end else if (i == 3'd3) begin
               s = '{1'b0, ida, '0, 1'b0};
            end
         end
         OP_SEC_ENTER, OP_SEC_EXIT: begin
            if (i == 3'd2) begin
               s = '{1'b1, UNLOCK_A1,
                     {8'h00, (op == OP_SEC_ENTER) ? CMD_SEC_ENTER : CMD_SEC_EXIT}, 1'b1};
            end
         end
         default: s = '{1'b0, '0, '0, 1'b1};
      endcase
      return s;
   endfunction

   fip_step_s cur;
   logic is_id, refuse, hv_op;
   always_comb begin
      cur = step_of(r.op, r.step, r.addr, r.wdata, r.item);
      is_id = (r.op == OP_ID_HV) || (r.op == OP_ID_CMD);
      hv_op = (r.op == OP_ID_HV);
      // unprotect only once every sector reads protected, never while secured mode is on
      refuse = ((OP == OP_UNPROT_WR) && (!(&r.prot) || r.secured))
         || (r.secured && (OP == OP_WRITE) && (WDATA[7:0] == CMD_BYPASS))
         || ((OP == OP_SEC_READ) && ESN_ONLY && r.locked && (ADDR[6:0] > ESN_LAST));
      next_r = r;
      next_r.done = 1'b0;
      next_r.s1 = F_DQ_I;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.pin.reset_hv = TEMP_UNPROT
         || ((r.st != S_IDLE) && ((r.op == OP_PROT_WR) || (r.op == OP_UNPROT_WR)));
      unique case (r.st)
         S_IDLE: begin
            if (REQ && refuse) begin
               next_r.done = 1'b1;
               next_r.err = 1'b1;
            end else if (REQ) begin
               next_r.op = OP;
               next_r.item = ITEM;
               next_r.addr = ADDR;
               next_r.wdata = WDATA;
               next_r.sector = SECTOR;
               next_r.step = '0;
               next_r.err = 1'b0;
               if (OP == OP_HW_RESET) begin
                  next_r.st = S_RSTP;
                  next_r.cnt = CNT_W'(RST_CYC);
                  next_r.pin.reset_n = 1'b0;
               end else begin
                  next_r.st = S_SETUP;
                  // hold the elevated level long enough to settle before strobing
                  next_r.cnt = (OP == OP_ID_HV) ? CNT_W'(HV_CYC) : CNT_W'(1);
                  next_r.pin.a9_hv = (OP == OP_ID_HV);
               end
            end
         end
         S_SETUP: begin
            next_r.pin.ce_n = 1'b0;
            next_r.pin.addr = cur.addr;
            next_r.pin.dq_o = cur.data;
            next_r.pin.dq_oe = cur.wr;
            next_r.cnt = r.cnt - CNT_W'(1);
            if (r.cnt == CNT_W'(1)) begin
               next_r.st = S_STROBE;
               next_r.cnt = cur.wr ? CNT_W'(WE_CYC) : CNT_W'(ACC_CYC);
               next_r.pin.we_n = !cur.wr;
               next_r.pin.oe_n = cur.wr;
            end
         end
         S_STROBE: begin
            if (r.cnt > CNT_W'(1)) begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end else if (cur.wr || (r.s2 == r.s3)) begin
               if (!cur.wr) begin
                  next_r.rdata = is_id ? {8'h00, r.s3[7:0]} : r.s3;
               end
               next_r.pin.we_n = 1'b1;
               next_r.pin.oe_n = 1'b1;
               next_r.st = S_HOLD;
            end
         end
         S_HOLD: begin
            next_r.pin.ce_n = 1'b1;
            next_r.pin.dq_oe = 1'b0;
            if (cur.last) begin
               next_r.st = S_DONE;
               next_r.pin.a9_hv = 1'b0;
            end else begin
               next_r.step = r.step + 3'd1;
               next_r.cnt = CNT_W'(1);
               next_r.st = S_SETUP;
            end
         end
         S_DONE: begin
            next_r.st = S_IDLE;
            next_r.done = 1'b1;
            if (r.op == OP_SEC_ENTER) next_r.secured = 1'b1;
            if (r.op == OP_SEC_EXIT) next_r.secured = 1'b0;
            if (is_id && (r.item == ID_PROT)) begin
               next_r.prot[r.sector] = r.rdata[PROT_BIT];
               next_r.err = (r.rdata[7:0] != PROT_NO) && (r.rdata[7:0] != PROT_YES);
            end
            if (is_id && (r.item == ID_SECIND)) begin
               next_r.locked = r.rdata[IND_LOCK_BIT];
               next_r.err = (r.rdata[7:0] != IND_LOCKED) && (r.rdata[7:0] != IND_OPEN);
            end
         end
         S_RSTP: begin
            next_r.cnt = r.cnt - CNT_W'(1);
            if (r.cnt == CNT_W'(1)) begin
               next_r.pin.reset_n = 1'b1;
               next_r.secured = 1'b0;
               next_r.st = S_DONE;
            end
         end
         default: next_r.st = S_IDLE;
      endcase
   end
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         r <= '0;
         r.st <= S_IDLE;
         r.pin.ce_n <= 1'b1;
         r.pin.oe_n <= 1'b1;
         r.pin.we_n <= 1'b1;
         r.pin.reset_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   assign READY = (r.st == S_IDLE);
   assign DONE = r.done;
   assign ERR = r.err;
   assign RDATA = r.rdata;
   assign SECURED = r.secured;
   assign FACTORY_LOCKED = r.locked;
   assign PROT_MAP = r.prot;
   assign F_ADDR = r.pin.addr;
   assign F_DQ_O = r.pin.dq_o;
   assign F_DQ_OE = r.pin.dq_oe;
   assign F_CE_N = r.pin.ce_n;
   assign F_OE_N = r.pin.oe_n;
   assign F_WE_N = r.pin.we_n;
   assign F_RESET_N = r.pin.reset_n;
   assign F_RESET_HV_EN = r.pin.reset_hv;
   assign F_A9_HV_EN = r.pin.a9_hv;
   assign F_BYTE_N = !BYTE_MODE;
   assign F_ACC_EN = ACC_REQ && !r.secured;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   AST_HV_HELD: assert property ((r.st == S_STROBE && r.op == OP_ID_HV) |-> F_A9_HV_EN)
      else $error("a9 elevated level dropped during id read");
   AST_ID_ADDR: assert property ((r.st == S_STROBE && hv_op) |->
      (F_ADDR[A6_POS] == r.item[2] && F_ADDR[1:0] == r.item[1:0]))
      else $error("id select lines wrong");
   AST_PROT_MAP: assert property ((r.st == S_DONE && is_id && r.item == ID_PROT) |=>
      PROT_MAP[r.sector] == r.rdata[PROT_BIT])
      else $error("protection map not updated");
   AST_LOCK: assert property ((r.st == S_DONE && is_id && r.item == ID_SECIND) |=>
      FACTORY_LOCKED == $past(r.rdata[IND_LOCK_BIT]))
      else $error("lock flag not taken from bit seven");
   AST_CMD_NO_HV: assert property ((r.op == OP_ID_CMD) |-> !F_A9_HV_EN)
      else $error("command id path used elevated level");
   AST_UNPROT: assert property ((READY && REQ && OP == OP_UNPROT_WR && !(&PROT_MAP)) |=>
      (READY && DONE && ERR))
      else $error("unprotect taken with unprotected sectors");
   AST_RST_HV: assert property ((r.st == S_STROBE && r.op == OP_PROT_WR) |-> F_RESET_HV_EN)
      else $error("protect write without elevated reset");
   AST_TEMP: assert property (TEMP_UNPROT |=> F_RESET_HV_EN)
      else $error("temporary unprotect not driven");
   AST_SEC_ADDR: assert property ((r.st == S_STROBE && r.op == OP_SEC_READ) |->
      F_ADDR[ADDR_W-1:7] == SEC_BASE[ADDR_W-1:7])
      else $error("secured read outside region");
   AST_RST_EXIT: assert property ((r.st == S_RSTP && r.cnt == CNT_W'(1)) |=> !SECURED)
      else $error("secured mode kept over reset");
   AST_ACC: assert property (SECURED |-> !F_ACC_EN)
      else $error("accelerated program offered in secured mode");
   AST_ID_BYTE: assert property ((DONE && !ERR && is_id) |-> RDATA[15:8] == 8'h00)
      else $error("upper byte leaked on id read");

   COV_ID_HV: cover property (r.st == S_DONE && r.op == OP_ID_HV);
   COV_ID_CMD: cover property (r.st == S_DONE && r.op == OP_ID_CMD && r.item == ID_SECIND);
   COV_SEC: cover property (SECURED && r.st == S_DONE && r.op == OP_SEC_READ);
   COV_REFUSE: cover property (DONE && ERR && r.op != OP_ID_HV);
endmodule
`default_nettype wire

/* testbench/fip_flash_model.sv */
// behavioural flash device answering identification, protection and secured-region cycles
`timescale 1ns/100ps
`default_nettype none
module fip_flash_model
   import fip_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'hA1, // arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'hB2, // arbitrary value
   parameter logic FACTORY_LOCK = 1'b1,
   parameter int DLY_NS = 40
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_o,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic reset_hv,
   input wire logic a9_hv,
   input wire logic byte_n,
   output logic [DATA_W-1:0] dq_i,
   output logic secured_mode
);
   logic prot [256];
   logic autosel = 1'b0;
   int cyc = 0;
   logic [DATA_W-1:0] last = 16'h0000;
   logic [DATA_W-1:0] val;
   initial begin
      foreach (prot[i]) prot[i] = 1'b0;
      secured_mode = 1'b0;
      dq_i = 16'hFFFF;
   end
   always @* begin
      val = addr[15:0] ^ 16'h5A5A;
      if (a9_hv || autosel) begin
         case ({addr[A6_POS], addr[1:0]})
            3'h0: val = {8'h00, MAKER_CODE};
            3'h1: val = {8'h00, DEVICE_CODE};
            3'h2: val = {15'h0000, prot[addr[19:12]]};
            3'h5: val = {8'h00, FACTORY_LOCK, 7'h03};
            default: val = 16'h0000;
         endcase
         // upper lines are not meaningful in byte mode, so they carry noise
         if (!byte_n) val[15:8] = 8'($urandom);
      end else if (secured_mode && addr[19:7] == 13'h1F00) begin
         // region is read-only here: no write path reaches it
         val = 16'hE500 | 16'(addr[6:0]);
      end
   end
   always @(negedge oe_n or negedge ce_n) begin
      if (!oe_n && !ce_n) begin
         #(DLY_NS);
         dq_i = val;
         last = val;
      end
   end
   // released bus shows no stale value
   always @(posedge oe_n or posedge ce_n) begin
      #10;
      dq_i = ~last;
   end
   always @(posedge we_n) begin
      if (!ce_n) begin
         // with the reset pin elevated, A6 low protects the addressed sector and A6 high clears every sector
         if (reset_hv) begin
            if (!addr[A6_POS]) begin
               prot[addr[19:12]] = 1'b1;
            end else begin
               foreach (prot[i]) prot[i] = 1'b0;
            end
         end else if (cyc == 0 && addr == UNLOCK_A1 && dq_o[7:0] == 8'h11) begin
            cyc = 1;
         end else if (cyc == 1 && addr == UNLOCK_A2 && dq_o[7:0] == 8'h22) begin
            cyc = 2;
         end else if (cyc == 2 && addr == UNLOCK_A1) begin
            autosel = autosel | (dq_o[7:0] == 8'h33);
            if (dq_o[7:0] == 8'h55) secured_mode = 1'b1;
            if (dq_o[7:0] == 8'h66) secured_mode = 1'b0;
            cyc = 0;
         end else begin
            if (dq_o[7:0] == 8'h44) autosel = 1'b0;
            cyc = 0;
         end
      end
   end
   always @(negedge reset_n) begin
      secured_mode = 1'b0;
      autosel = 1'b0;
      cyc = 0;
   end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the flash identification and protection host
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import fip_pkg::*;
   logic CORE_CLK = 1'b0;
   logic SRST = 1'b1;
   logic REQ = 1'b0;
   fip_op_e OP = OP_READ;
   fip_item_e ITEM = ID_MAKER;
   logic [ADDR_W-1:0] ADDR = 20'h0_0000;
   logic [DATA_W-1:0] WDATA = 16'h0000;
   logic [5:0] SECTOR = 6'h00;
   logic BYTE_MODE = 1'b0;
   logic ACC_REQ = 1'b0;
   logic TEMP_UNPROT = 1'b0;
   logic READY, DONE, ERR, SECURED, FACTORY_LOCKED, F_DQ_OE, F_CE_N, F_OE_N, F_WE_N;
   logic F_RESET_N, F_RESET_HV_EN, F_A9_HV_EN, F_BYTE_N, F_ACC_EN, model_sec;
   logic [DATA_W-1:0] RDATA, F_DQ_I, F_DQ_O;
   logic [NUM_SECT-1:0] PROT_MAP;
   logic [ADDR_W-1:0] F_ADDR;
   logic saw_a9, saw_rhv, saw_ce;
   int fails = 0;
   int comparisons = 0;
   fip_item_e items [3] = '{ID_MAKER, ID_DEVICE, ID_SECIND};
   logic [7:0] exp_id [3] = '{8'hA1, 8'hB2, 8'h83};
   int off;
   int ref_dev [NUM_SECT];
   int ref_map [NUM_SECT];
   int ref_sec = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;
   fip_host DUT (.CORE_CLK(CORE_CLK), .SRST(SRST), .REQ(REQ), .READY(READY), .OP(OP),
      .ITEM(ITEM), .ADDR(ADDR), .WDATA(WDATA), .SECTOR(SECTOR), .BYTE_MODE(BYTE_MODE),
      .ACC_REQ(ACC_REQ), .TEMP_UNPROT(TEMP_UNPROT), .DONE(DONE), .ERR(ERR), .RDATA(RDATA),
      .SECURED(SECURED), .FACTORY_LOCKED(FACTORY_LOCKED), .PROT_MAP(PROT_MAP),
      .F_ADDR(F_ADDR), .F_DQ_I(F_DQ_I), .F_DQ_O(F_DQ_O), .F_DQ_OE(F_DQ_OE), .F_CE_N(F_CE_N),
      .F_OE_N(F_OE_N), .F_WE_N(F_WE_N), .F_RESET_N(F_RESET_N), .F_RESET_HV_EN(F_RESET_HV_EN),
      .F_A9_HV_EN(F_A9_HV_EN), .F_BYTE_N(F_BYTE_N), .F_ACC_EN(F_ACC_EN));
   fip_flash_model flash (.addr(F_ADDR), .dq_o(F_DQ_O), .ce_n(F_CE_N), .oe_n(F_OE_N),
      .we_n(F_WE_N), .reset_n(F_RESET_N), .reset_hv(F_RESET_HV_EN), .a9_hv(F_A9_HV_EN),
      .byte_n(F_BYTE_N), .dq_i(F_DQ_I), .secured_mode(model_sec));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one operation: request held until the taking edge, then wait for the done pulse
   task automatic run(input fip_op_e op, input fip_item_e it, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, input logic [5:0] s);
      int n;
      int all;
      logic [NUM_SECT-1:0] m;
      n = 0;
      OP = op;
      ITEM = it;
      ADDR = a;
      WDATA = wd;
      SECTOR = s;
      REQ = 1'b1;
      @(posedge CORE_CLK);
      #1;
      REQ = 1'b0;
      saw_a9 = F_A9_HV_EN;
      saw_rhv = F_RESET_HV_EN;
      saw_ce = !F_CE_N;
      while (DONE !== 1'b1) begin
         @(posedge CORE_CLK);
         #1;
         saw_a9 |= F_A9_HV_EN;
         saw_rhv |= F_RESET_HV_EN;
         saw_ce |= !F_CE_N;
         n++;
         if (n > 2000) begin
            fails++;
            give_verdict();
         end
      end
      // reference model: device protection, map as the host last read it, secured mode
      all = 1;
      foreach (ref_map[i]) all &= ref_map[i];
      if (op == OP_PROT_WR) ref_dev[s] = 1;
      if (op == OP_UNPROT_WR && ref_sec == 0 && all == 1) begin
         foreach (ref_dev[i]) ref_dev[i] = 0;
      end
      if ((op == OP_ID_CMD || op == OP_ID_HV) && it == ID_PROT) ref_map[s] = ref_dev[s];
      if (op == OP_SEC_ENTER) ref_sec = 1;
      if (op == OP_SEC_EXIT || op == OP_HW_RESET) ref_sec = 0;
      foreach (ref_map[i]) m[i] = ref_map[i][0];
      chk({PROT_MAP, SECURED}, {m, 1'(ref_sec)});
      // let an edge pass so a refused request is never followed by a raise in the same step
      @(posedge CORE_CLK);
      #1;
   endtask
   function automatic logic [ADDR_W-1:0] sect_addr(input int k);
      int b;
      b = (k == 0) ? 0 : (k < 3) ? k + 1 : (k == 3) ? 4 : (k - 3) * 8;
      return {8'(b), 12'h000};
   endfunction
   initial begin
      void'($urandom(15942));
      repeat (10) @(posedge CORE_CLK);
      #1;
      SRST = 1'b0;
      chk({READY, SECURED, FACTORY_LOCKED, PROT_MAP}, {3'h4, 35'h0});
      chk({F_RESET_HV_EN, F_A9_HV_EN, F_CE_N}, 3'h1);
      foreach (items[i]) begin
         BYTE_MODE = 1'($urandom);
         run(OP_ID_HV, items[i], 20'h0_0000, 16'h0000, 6'h00);
         chk({RDATA, saw_a9, F_BYTE_N}, {8'h00, exp_id[i], 1'b1, !BYTE_MODE});
      end
      chk(FACTORY_LOCKED, 1'b1);
      BYTE_MODE = 1'b0;
      run(OP_ID_CMD, ID_DEVICE, 20'h0_0000, 16'h0000, 6'h00);
      chk({RDATA, saw_a9, ERR}, {16'h00B2, 2'h0});
      run(OP_ID_CMD, ID_PROT, sect_addr(0), 16'h0000, 6'h00);
      chk({RDATA, PROT_MAP[0]}, {16'h0000, 1'b0});
      run(OP_UNPROT_WR, ID_MAKER, sect_addr(0) | 20'h0_0040, 16'h0000, 6'h00);
      chk({ERR, saw_ce}, 2'h2);
      for (int k = 0; k < NUM_SECT; k++) begin
         run(OP_PROT_WR, ID_MAKER, sect_addr(k), 16'h0000, 6'(k));
         chk({saw_rhv, saw_a9}, 2'h2);
         run(OP_ID_CMD, ID_PROT, sect_addr(k), 16'h0000, 6'(k));
         chk({RDATA, PROT_MAP[k]}, {16'h0001, 1'b1});
      end
      run(OP_SEC_ENTER, ID_MAKER, 20'h0_0000, 16'h0000, 6'h00);
      run(OP_UNPROT_WR, ID_MAKER, sect_addr(0) | 20'h0_0040, 16'h0000, 6'h00);
      chk({ERR, saw_ce}, 2'h2);
      run(OP_SEC_EXIT, ID_MAKER, 20'h0_0000, 16'h0000, 6'h00);
      run(OP_UNPROT_WR, ID_MAKER, sect_addr(0) | 20'h0_0040, 16'h0000, 6'h00);
      chk({ERR, saw_rhv}, 2'h1);
      off = $urandom_range(NUM_SECT - 1);
      run(OP_ID_CMD, ID_PROT, sect_addr(off), 16'h0000, 6'(off));
      chk({RDATA, PROT_MAP[off]}, {16'h0000, 1'b0});
      ACC_REQ = 1'b1;
      run(OP_SEC_ENTER, ID_MAKER, 20'h0_0000, 16'h0000, 6'h00);
      chk({SECURED, model_sec, F_ACC_EN}, 3'h6);
      off = $urandom_range(7);
      run(OP_SEC_READ, ID_MAKER, 20'(off), 16'h0000, 6'h00);
      chk({ERR, RDATA}, {1'b0, 16'hE500 | 16'(off)});
      run(OP_SEC_READ, ID_MAKER, 20'h0_0008, 16'h0000, 6'h00);
      chk({ERR, saw_ce}, 2'h2);
      run(OP_WRITE, ID_MAKER, UNLOCK_A1, 16'h0077, 6'h00);
      chk({ERR, saw_ce}, 2'h2);
      run(OP_SEC_EXIT, ID_MAKER, 20'h0_0000, 16'h0000, 6'h00);
      chk({SECURED, model_sec, F_ACC_EN}, 3'h1);
      run(OP_SEC_ENTER, ID_MAKER, 20'h0_0000, 16'h0000, 6'h00);
      run(OP_HW_RESET, ID_MAKER, 20'h0_0000, 16'h0000, 6'h00);
      chk({SECURED, model_sec}, 2'h0);
      run(OP_READ, ID_MAKER, SEC_BASE | 20'h0_0003, 16'h0000, 6'h00);
      chk(RDATA, (SEC_BASE[15:0] | 16'h0003) ^ 16'h5A5A);
      TEMP_UNPROT = 1'b1;
      @(posedge CORE_CLK);
      #1;
      chk(F_RESET_HV_EN, 1'b1);
      TEMP_UNPROT = 1'b0;
      @(posedge CORE_CLK);
      #1;
      chk(F_RESET_HV_EN, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
